// [rtl/bts_pkg.sv]
package bts_pkg;

    // Sizes
    localparam int NUM_EV   = 5;
    localparam int NUM_SEQ  = 5;
    localparam int NUM_TRAP = 2;
    localparam int NUM_SLOT = 4;
    localparam int LINES    = 64;
    localparam int PTR_W    = 6;
    localparam int ADDR_W   = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CFG       = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] REG_INT_STAT  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_INT_MASK  = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_RD_INDEX  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_RD_FMT    = 8'h14;
    localparam logic [ADDR_W-1:0] REG_RD_SLOT0  = 8'h18;
    localparam logic [ADDR_W-1:0] REG_TRAP_BASE = 8'h24;
    localparam logic [ADDR_W-1:0] REG_EV_BASE   = 8'h40;
    localparam logic [ADDR_W-1:0] REG_SEQ_BASE  = 8'h60;

    // Configuration register bits
    localparam int CFG_FREEZE_FULL = 0;
    localparam int CFG_FREEZE      = 1;
    localparam int CFG_RESTART     = 2;
    localparam int CFG_START       = 3;
    localparam int CFG_STOP        = 4;

    // Status register bits
    localparam int ST_ACTIVE  = 0;
    localparam int ST_FROZEN  = 1;
    localparam int ST_WRAPPED = 2;
    localparam int ST_WP_LSB  = 8;

    // Interrupt status and mask bits
    localparam int INT_W     = 3;
    localparam int INT_FULL  = 0;
    localparam int INT_START = 1;
    localparam int INT_STOP  = 2;

    // Event detector configuration fields
    localparam int EV_ID_A  = 0;
    localparam int EV_ID_B  = 4;
    localparam int EV_USE_A = 8;
    localparam int EV_USE_B = 9;
    localparam int EV_READ  = 10;
    localparam int EV_WRITE = 11;
    localparam int EV_TRAP0 = 12;
    localparam int EV_DATA  = 14;
    localparam int EV_EN    = 15;

    // Sequence trigger configuration fields
    localparam int SLOT_W    = 3;
    localparam int SEQ_START = 12;
    localparam int SEQ_STOP  = 13;
    localparam int SEQ_ASAMP = 14;
    localparam int SEQ_DSAMP = 15;
    localparam int SEQ_EN    = 16;
    localparam logic [SLOT_W-1:0] SLOT_FIFTH = 3'h4;

    // Reset values and bus answers
    localparam logic [31:0] RST_WORD    = 32'h0;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        valid;
        logic [3:0]  req_id;
        logic        write;
        logic [31:0] addr;
    } bts_addr_phase_s;

    typedef struct packed {
        logic        valid;
        logic [3:0]  responding_source_field;
        logic [3:0]  transaction_initiator_field;
        logic [31:0] data;
    } bts_data_phase_s;

    typedef struct packed {
        logic              is_ad;
        logic [1:0]        count;
        logic [2:0][31:0]  slot;
    } bts_line_s;

endpackage

// [rtl/bts_line_mem.sv]
`timescale 1ns/1ps
module bts_line_mem (
    // Clock
    input  wire  logic                     aclk,
    // Write port
    input  wire  logic                     we,
    input  wire  logic [bts_pkg::PTR_W-1:0] waddr,
    input  wire  bts_pkg::bts_line_s       wdata,
    // Read port
    input  wire  logic [bts_pkg::PTR_W-1:0] raddr,
    output bts_pkg::bts_line_s             rdata
);
    import bts_pkg::*;

    bts_line_s mem [LINES];

    // No reset on the array; readout masks lines never written
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// [rtl/bts_seq_unit.sv]
`timescale 1ns/1ps
module bts_seq_unit (
    // Clock and reset
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    // Configuration
    input  wire logic                             enable,
    input  wire logic                             fifth_ok,
    input  wire logic [bts_pkg::NUM_SLOT*bts_pkg::SLOT_W-1:0] slots,
    // Events and result
    input  wire logic [bts_pkg::NUM_EV-1:0]       ev_hit,
    output logic                                  fire
);
    import bts_pkg::*;

    logic [1:0]        step;
    logic [1:0]        next_step;
    logic [2:0]        adv;
    logic              used;
    logic [SLOT_W-1:0] code;
    logic              hit;

    // One event may satisfy only one listed slot per cycle, so order is kept
    always_comb begin
        adv  = {1'b0, step};
        used = 1'b0;
        code = '0;
        hit  = 1'b0;
        for (int k = 0; k < NUM_SLOT; k++) begin
            if (adv == 3'(k)) begin
                code = slots[k*SLOT_W +: SLOT_W];
                hit  = (code < SLOT_FIFTH) ? ev_hit[code[1:0]]
                     : (code == SLOT_FIFTH) && fifth_ok && ev_hit[NUM_EV-1];  // see R13
                if (code > SLOT_FIFTH) begin
                    adv = adv + 3'h1;  // see R8
                end else if (!used && hit) begin
                    adv  = adv + 3'h1;  // see R8
                    used = 1'b1;
                end
            end
        end
        fire      = enable && adv == 3'(NUM_SLOT);
        next_step = (!enable || fire) ? 2'h0 : adv[1:0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step <= 2'h0;
        end else begin
            step <= next_step;
        end
    end
endmodule

// [rtl/bts_trace_seq.sv]
`timescale 1ns/1ps
// Behaviour
// R1 - A firing sequence trigger with the start action begins trace collection.
// R2 - While collecting, an address-sample trigger writes the matching request's address into the trace memory.
// R3 - A firing sequence trigger with the stop action halts collection until the next start.
// R4 - With freeze when full selected, a full memory freezes, refuses samples and raises the interrupt.
// R5 - Software resets and restarts the buffer through the configuration register, collecting from empty.
// R6 - Without freeze when full the memory is circular and overwrites the oldest lines until software freezes it.
// R7 - After a freeze software reads the memory and no new sample alters it.
// R8 - A sequence trigger fires only after its non-ignored events occur in listed order; ignore slots always pass.
// R9 - A firing data-sample trigger stores the data transfer as an address/data sample. The code drops it while a split line still waits in pend.
// R10 - Data-phase detectors compare responding source and transaction initiator fields with programmed values.
// R11 - Address-phase detectors match requester, direction and optionally an address trap range hit.
// R12 - A data sample after address samples closes the partial line, so the address/data sample takes a fresh line.
// R13 - The fifth event detector is usable only by the fifth sequence trigger.
// R14 - Readout returns lines newest first, the earliest retained line last.
// R15 - While stopped or frozen, sample actions write nothing into the trace memory.
module bts_trace_seq (
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite write address and data
    input  wire logic [bts_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]              awprot,
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    // AXI4-Lite write response
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    // AXI4-Lite read
    input  wire logic [bts_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]              arprot,
    input  wire logic                    arvalid,
    output logic                         arready,
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    // Observed system bus
    input  wire bts_pkg::bts_addr_phase_s addr_phase,
    input  wire bts_pkg::bts_data_phase_s data_phase,
    // Interrupt
    output logic                         irq
);
    import bts_pkg::*;

    // Register state
    logic                  freeze_when_full;
    logic [INT_W-1:0]      int_stat;
    logic [INT_W-1:0]      int_mask;
    logic [PTR_W-1:0]      rd_index;
    logic [31:0]           trap_reg [2*NUM_TRAP];
    logic [31:0]           ev_cfg   [NUM_EV];
    logic [31:0]           seq_cfg  [NUM_SEQ];

    // Trace state
    logic                  collecting;
    logic                  frozen;
    logic                  wrapped;
    logic [PTR_W-1:0]      wp;
    bts_line_s             cur;
    bts_line_s             pend;
    logic                  pend_valid;
    logic [31:0]           last_addr;
    logic                  rd_ok;

    // AXI state
    logic [ADDR_W-1:0]     aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  axi_up;

    // Write decode
    wire logic             wr_go    = axi_up && !awready && !wready && !bvalid;
    wire logic [31:0]      wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire logic [31:0]      wbits    = w_data & wmask;
    wire logic             wr_cfg   = wr_go && aw_addr == REG_CFG;
    wire logic             wr_istat = wr_go && aw_addr == REG_INT_STAT;
    wire logic             wr_imask = wr_go && aw_addr == REG_INT_MASK;
    wire logic             wr_ridx  = wr_go && aw_addr == REG_RD_INDEX;
    wire logic [ADDR_W-1:0] trap_off = aw_addr - REG_TRAP_BASE;
    wire logic [ADDR_W-1:0] ev_off   = aw_addr - REG_EV_BASE;
    wire logic [ADDR_W-1:0] seq_off  = aw_addr - REG_SEQ_BASE;
    wire logic             wr_trap  = wr_go && aw_addr >= REG_TRAP_BASE && trap_off < 8'(4*2*NUM_TRAP);
    wire logic             wr_ev    = wr_go && aw_addr >= REG_EV_BASE && ev_off < 8'(4*NUM_EV);
    wire logic             wr_seq   = wr_go && aw_addr >= REG_SEQ_BASE && seq_off < 8'(4*NUM_SEQ);
    wire logic             wr_known = wr_cfg || wr_istat || wr_imask || wr_ridx || wr_trap || wr_ev || wr_seq
                                      || aw_addr == REG_STATUS;

    // Software commands carried by configuration writes
    wire logic             sw_freeze  = wr_cfg && wbits[CFG_FREEZE];
    wire logic             sw_restart = wr_cfg && wbits[CFG_RESTART];
    wire logic             sw_start   = wr_cfg && wbits[CFG_START];
    wire logic             sw_stop    = wr_cfg && wbits[CFG_STOP];

    // Address traps and event detectors
    logic [NUM_TRAP-1:0]   trap_hit;
    logic [NUM_EV-1:0]     ev_hit;
    logic [NUM_SEQ-1:0]    seq_fire;
    logic [NUM_SEQ-1:0]    act_start;
    logic [NUM_SEQ-1:0]    act_stop;
    logic [NUM_SEQ-1:0]    act_asamp;
    logic [NUM_SEQ-1:0]    act_dsamp;

    genvar g;
    generate
        for (g = 0; g < NUM_TRAP; g++) begin : g_trap
            assign trap_hit[g] = addr_phase.addr >= trap_reg[2*g] && addr_phase.addr <= trap_reg[2*g+1];
        end
        for (g = 0; g < NUM_EV; g++) begin : g_ev
            wire logic [31:0] c     = ev_cfg[g];
            wire logic        a_hit = addr_phase.valid
                && (!c[EV_USE_A] || addr_phase.req_id == c[EV_ID_A +: 4])
                && (addr_phase.write ? c[EV_WRITE] : c[EV_READ])
                && (!c[EV_TRAP0] || trap_hit[0])
                && (!c[EV_TRAP0+1] || trap_hit[1]);  // see R11
            wire logic        d_hit = data_phase.valid
                && (!c[EV_USE_A] || data_phase.responding_source_field == c[EV_ID_A +: 4])
                && (!c[EV_USE_B] || data_phase.transaction_initiator_field == c[EV_ID_B +: 4]);  // see R10
            assign ev_hit[g] = c[EV_EN] && (c[EV_DATA] ? d_hit : a_hit);
        end
        for (g = 0; g < NUM_SEQ; g++) begin : g_seq
            bts_seq_unit u_seq (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .enable   (seq_cfg[g][SEQ_EN]),
                .fifth_ok (g == NUM_SEQ - 1),
                .slots    (seq_cfg[g][NUM_SLOT*SLOT_W-1:0]),
                .ev_hit   (ev_hit),
                .fire     (seq_fire[g])
            );
            assign act_start[g] = seq_fire[g] && seq_cfg[g][SEQ_START];
            assign act_stop[g]  = seq_fire[g] && seq_cfg[g][SEQ_STOP];
            assign act_asamp[g] = seq_fire[g] && seq_cfg[g][SEQ_ASAMP];
            assign act_dsamp[g] = seq_fire[g] && seq_cfg[g][SEQ_DSAMP];
        end
    endgenerate

    // Sampling gates
    wire logic             hw_start  = |act_start;
    wire logic             hw_stop   = |act_stop;
    wire logic             sample_ok = collecting && !frozen;  // see R15
    wire logic             take_d    = sample_ok && |act_dsamp && data_phase.valid && !pend_valid;  // see R9
    wire logic             take_a    = sample_ok && |act_asamp && addr_phase.valid && !take_d;  // see R2

    // Address/data line; the address is that of the latest observed request
    wire bts_line_s        ad_line   = '{is_ad: 1'b1, count: 2'h1,
        slot: {24'h0, data_phase.responding_source_field, data_phase.transaction_initiator_field,
               data_phase.data, last_addr}};

    // Line assembly; one memory write per cycle, a split line waits in pend
    bts_line_s             next_cur;
    bts_line_s             next_pend;
    logic                  next_pend_valid;
    logic                  we;
    bts_line_s             wline;

    always_comb begin
        next_cur        = cur;
        next_pend       = pend;
        next_pend_valid = 1'b0;
        we              = 1'b0;
        wline           = cur;
        if (pend_valid) begin
            we    = 1'b1;
            wline = pend;
        end
        if (take_d) begin
            if (cur.count != 2'h0) begin
                we              = 1'b1;  // see R12
                wline           = cur;
                next_pend       = ad_line;
                next_pend_valid = 1'b1;
                next_cur        = '0;
            end else begin
                we    = 1'b1;
                wline = ad_line;
            end
        end else if (take_a) begin
            next_cur.slot[cur.count] = addr_phase.addr;
            next_cur.count           = cur.count + 2'h1;
            if (cur.count == 2'h2) begin
                we       = 1'b1;
                wline    = next_cur;
                next_cur = '0;
            end
        end
    end

    wire logic             mem_we    = we && !frozen;  // see R7
    wire logic             last_line = wp == PTR_W'(LINES - 1);
    wire logic             fill_stop = mem_we && last_line && freeze_when_full;  // see R4

    // Readout walks backward from the newest line
    wire logic [PTR_W-1:0] rd_addr   = wp - PTR_W'(1) - rd_index;  // see R14
    wire logic             rd_in     = wrapped || rd_index < wp;
    bts_line_s             rd_line;

    bts_line_mem u_mem (
        .aclk  (aclk),
        .we    (mem_we),
        .waddr (wp),
        .wdata (wline),
        .raddr (rd_addr),
        .rdata (rd_line)
    );

    // Trace control
    always_ff @(posedge aclk) begin
        if (!aresetn || sw_restart) begin
            collecting <= sw_restart;  // see R5
            frozen     <= 1'b0;
            wrapped    <= 1'b0;
            wp         <= '0;
            cur        <= '0;
            pend       <= '0;
            pend_valid <= 1'b0;
        end else begin
            if (hw_stop || sw_stop) begin
                collecting <= 1'b0;  // see R3
            end else if (hw_start || sw_start) begin
                collecting <= 1'b1;  // see R1
            end
            if (fill_stop || sw_freeze) begin
                frozen <= 1'b1;  // see R6
            end
            if (mem_we) begin
                wp <= wp + PTR_W'(1);  // see R6
                if (last_line) begin
                    wrapped <= 1'b1;
                end
            end
            cur        <= next_cur;
            pend       <= next_pend;
            pend_valid <= next_pend_valid && !frozen;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_addr <= RST_WORD;
            rd_ok     <= 1'b0;
        end else begin
            if (addr_phase.valid) begin
                last_addr <= addr_phase.addr;
            end
            rd_ok <= rd_in;
        end
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freeze_when_full <= 1'b0;
            int_mask         <= '0;
            rd_index         <= '0;
            for (int i = 0; i < 2*NUM_TRAP; i++) begin
                trap_reg[i] <= RST_WORD;
            end
            for (int i = 0; i < NUM_EV; i++) begin
                ev_cfg[i]  <= RST_WORD;
                seq_cfg[i] <= RST_WORD;
            end
        end else begin
            if (wr_cfg && w_strb[0]) begin
                freeze_when_full <= w_data[CFG_FREEZE_FULL];
            end
            if (wr_imask && w_strb[0]) begin
                int_mask <= w_data[INT_W-1:0];
            end
            if (wr_ridx && w_strb[0]) begin
                rd_index <= w_data[PTR_W-1:0];
            end
            if (wr_trap) begin
                trap_reg[trap_off[3:2]] <= (trap_reg[trap_off[3:2]] & ~wmask) | wbits;
            end
            if (wr_ev) begin
                ev_cfg[ev_off[4:2]] <= (ev_cfg[ev_off[4:2]] & ~wmask) | wbits;
            end
            if (wr_seq) begin
                seq_cfg[seq_off[4:2]] <= (seq_cfg[seq_off[4:2]] & ~wmask) | wbits;
            end
        end
    end

    // Sticky events; a new event beats a same-cycle clear
    wire logic [INT_W-1:0] int_set = {INT_W{1'b0}} | (INT_W'(fill_stop) << INT_FULL)
                                     | (INT_W'(hw_start) << INT_START) | (INT_W'(hw_stop) << INT_STOP);
    wire logic [INT_W-1:0] int_clr = wr_istat ? wbits[INT_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat <= '0;
            irq      <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~int_clr) | int_set;
            irq      <= |(int_stat & int_mask);  // see R4
        end
    end

    // Read mux
    wire logic [ADDR_W-1:0] rd_slot_off = araddr - REG_RD_SLOT0;
    wire bts_line_s        rd_view     = rd_ok ? rd_line : '0;
    logic [31:0]           rd_word;
    logic                  rd_known;

    always_comb begin
        rd_word  = RST_WORD;
        rd_known = 1'b1;
        if (araddr == REG_CFG) begin
            rd_word[CFG_FREEZE_FULL] = freeze_when_full;
        end else if (araddr == REG_STATUS) begin
            rd_word[ST_ACTIVE]             = collecting;
            rd_word[ST_FROZEN]             = frozen;
            rd_word[ST_WRAPPED]            = wrapped;
            rd_word[ST_WP_LSB +: PTR_W]    = wp;
        end else if (araddr == REG_INT_STAT) begin
            rd_word[INT_W-1:0] = int_stat;
        end else if (araddr == REG_INT_MASK) begin
            rd_word[INT_W-1:0] = int_mask;
        end else if (araddr == REG_RD_INDEX) begin
            rd_word[PTR_W-1:0] = rd_index;
        end else if (araddr == REG_RD_FMT) begin
            rd_word[2:0] = {rd_view.is_ad, rd_view.count};
        end else if (araddr >= REG_RD_SLOT0 && rd_slot_off < 8'h0c) begin
            rd_word = rd_view.slot[rd_slot_off[3:2]];
        end else if (araddr >= REG_TRAP_BASE && araddr < REG_TRAP_BASE + 8'(4*2*NUM_TRAP)) begin
            rd_word = trap_reg[2'(araddr[3:2] - REG_TRAP_BASE[3:2])];
        end else if (araddr >= REG_EV_BASE && araddr < REG_EV_BASE + 8'(4*NUM_EV)) begin
            rd_word = ev_cfg[araddr[4:2]];
        end else if (araddr >= REG_SEQ_BASE && araddr < REG_SEQ_BASE + 8'(4*NUM_SEQ)) begin
            rd_word = seq_cfg[araddr[4:2]];
        end else begin
            rd_known = 1'b0;
        end
    end

    // AXI4-Lite slave: address and data taken in either order, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            aw_addr <= '0;
            w_data  <= RST_WORD;
            w_strb  <= '0;
            axi_up  <= 1'b0;
        end else if (bvalid) begin
            if (bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else begin
            axi_up  <= 1'b1;
            if (awready && awvalid) begin
                awready <= 1'b0;
                aw_addr <= {awaddr[ADDR_W-1:2], 2'b00};
            end else if (!awready && wready) begin
                awready <= 1'b0;
            end else begin
                awready <= 1'b1;
            end
            if (wready && wvalid) begin
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end else if (!wready && awready) begin
                wready <= 1'b0;
            end else begin
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= RST_WORD;
            rresp   <= RESP_OKAY;
        end else if (rvalid) begin
            if (rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end else if (arready && arvalid) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else begin
            arready <= 1'b1;
        end
    end
endmodule

// [test/bts_props.sv]
`timescale 1ns/1ps
module bts_chk (
    // Clock and reset
    input wire logic        aclk, aresetn,
    // Register bus handshakes
    input wire logic        awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic        arvalid, arready, rvalid, rready,
    input wire logic [1:0]  bresp,
    input wire logic [31:0] rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr; awvalid && awready && wvalid && wready; endsequence
    sequence s_rd; arvalid && arready; endsequence
    property p_aw_low; awvalid && awready |=> !awready; endproperty
    property p_ar_low; s_rd |=> !arready; endproperty
    property p_r_lat; s_rd |=> rvalid; endproperty
    property p_b_lat; s_wr |-> ##[1:3] bvalid; endproperty
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    property p_r_drop; rvalid && rready |=> !rvalid; endproperty
    property p_b_drop; bvalid && bready |=> !bvalid; endproperty
    a_aw_low: assert property (p_aw_low) else $error("awready high after take");
    a_ar_low: assert property (p_ar_low) else $error("arready high after take");
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    a_r_hold: assert property (p_r_hold) else $error("read answer unstable");
    a_b_hold: assert property (p_b_hold) else $error("write answer unstable");
    a_r_drop: assert property (p_r_drop) else $error("rvalid stuck");
    a_b_drop: assert property (p_b_drop) else $error("bvalid stuck");
endmodule
bind bts_trace_seq bts_chk i_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .bresp(bresp), .rdata(rdata));

// [test/bts_agent.sv]
`timescale 1ns/1ps
module bts_agent import bts_pkg::*; (
    // Clock
    input  wire logic aclk,
    // Observed phases
    output bts_addr_phase_s addr_phase,
    output bts_data_phase_s data_phase
);
    initial addr_phase = '0;
    initial data_phase = '0;
    // One request per cycle; released payload is inverted so stale values never match
    task automatic aburst(input logic [3:0] id, input logic [31:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            addr_phase <= '{valid: 1'b1, req_id: id, write: 1'b0, addr: b + 32'(4 * i)};
            @(posedge aclk);
        end
        addr_phase <= '{valid: 1'b0, req_id: ~id, write: 1'b1, addr: ~b};
        @(posedge aclk);
    endtask
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    import bts_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, v;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, irq;
    bts_addr_phase_s ap;
    bts_data_phase_s dp;
    int n_errors = 0, cmp_count = 0;
    always #12.5 aclk = ~aclk;
    bts_trace_seq i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .addr_phase(ap), .data_phase(dp), .irq(irq));
    bts_agent i_agt (.aclk(aclk), .addr_phase(ap), .data_phase(dp));
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 50) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid && n < 50);
        guard(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        araddr <= a;
        arvalid <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 0;
        end while (!rvalid && n < 50);
        v = rdata;
        r = rresp;
        guard(n);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        wr(REG_EV_BASE, 32'h8d01);
        wr(REG_SEQ_BASE + 8'h04, 32'h14ff8);
        wr(REG_INT_MASK, 32'h1);
        wr(REG_CFG, 32'h8);
        i_agt.aburst(4'h2, 32'h100, 3);
        i_agt.aburst(4'h1, 32'h200, 3);
        rd(REG_STATUS);
        chk("status", 32'h101, v);
        rd(REG_RD_FMT);
        chk("format", 32'h3, v);
        rd(REG_RD_SLOT0);
        chk("slot0", 32'h200, v);
        wr(REG_CFG, 32'h10);
        i_agt.aburst(4'h1, 32'h300, 3);
        rd(REG_STATUS);
        chk("stopped", 32'h100, v);
        wr(REG_CFG, 32'h5);
        i_agt.aburst(4'h1, 32'h0, 198);
        rd(REG_STATUS);
        chk("frozen", 32'h2, v & 32'h2);
        chk("irq", 32'h1, 32'(irq));
        rd(REG_RD_SLOT0);
        chk("newest", 32'h2f4, v);
        wr(REG_RD_INDEX, 32'h1);
        rd(REG_RD_SLOT0);
        chk("older", 32'h2e8, v);
        wr(REG_INT_STAT, 32'h1);
        rd(REG_INT_STAT);
        chk("int", 32'h0, v & 32'h1);
        chk("irq", 32'h0, 32'(irq));
        rd(8'hfc);
        chk("unmapped", {30'h0, RESP_SLVERR}, {v[29:0], r});
        wr(8'hfc, 32'h0);
        chk("bresp", 32'(RESP_SLVERR), 32'(bresp));
        wr(REG_EV_BASE + 8'h10, 32'h8d01);
        wr(REG_SEQ_BASE, 32'h12ffc);
        i_agt.aburst(4'h1, 32'h0, 1);
        rd(REG_STATUS);
        chk("fifth", 32'h1, v & 32'h1);
        tally_and_finish();
    end
endmodule
